// ==== rtl/ddm_slave_channel.sv ====
// Purpose: Distributed DMA slave channel registers and request control.
// Assumes: Byte I/O window on ref_clk; transfer engine on ref_clk.
// Notes:   Card request pin is synchronised; all else is same-clock.
//
// Overview of operation
// - Count register: write base, read current, reset zero
// - Narrow transfers reduce count by one
// - Wide transfers reduce count by two
// - Control bit two set disables the channel
// - Other control bits read-only, read zero
// - Offset eight reads status, writes control
// - Four request bits follow card request line
// - Request bits ignore the socket mask
// - Terminal count sets all four flags
// - Flags clear on status read or reset
// - Any trigger write starts software request
// - Setup bits 7-6 pick demand/single/block mode
// - Setup bit 5 picks address direction
// - Setup bit 4 enables auto reload
// - Setup bits 3-2 pick transfer direction
// - Setup low two bits read zero
// - Socket mask set ignores card requests
// - Clear-location write resets whole channel
// - Reserved locations read zero, ignore writes
`timescale 1ns/100ps
`default_nettype none
module ddm_slave_channel (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        card_request_line,
  input  wire logic        socket_request_mask,
  input  wire logic        xfer_done,
  input  wire logic        xfer_wide,
  output logic             dma_req,
  output logic      [15:0] cur_address,
  output logic      [15:0] cur_count,
  output logic             address_direction,
  output logic      [1:0]  transfer_direction_type
);

  // ----------------------------------------------------------------
  // Decode and synchronised card request
  // ----------------------------------------------------------------
  logic              card_req_s;
  logic              wr_addr_lo;
  logic              wr_addr_hi;
  logic              wr_count_lo;
  logic              wr_count_hi;
  logic              wr_ctrl;
  logic              wr_trigger;
  logic              wr_setup;
  logic              master_clear;
  logic              rd_status;
  logic              channel_disable_bit;
  logic [7:0]        setup;
  logic [3:0]        terminal_count_flags;
  logic [3:0]        card_request_status;
  logic              sw_pend;
  logic [15:0]       base_count;
  logic [15:0]       base_address;
  logic [15:0]       count_step;
  logic              in_run;
  logic              tc_event;
  logic              auto_reload_enable;
  logic              card_ok;
  ddm_pkg::ddm_mode_e  operating_mode_select;
  ddm_pkg::ddm_state_e state;
  ddm_pkg::ddm_state_e next_state;

  ddm_sync u_req_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in (card_request_line),
    .sync_out (card_req_s)
  );

  // Unlisted offsets decode to nothing, so writes there are dropped
  assign wr_addr_lo   = io_wr && (io_addr == ddm_pkg::OFS_ADDR_LO);
  assign wr_addr_hi   = io_wr && (io_addr == ddm_pkg::OFS_ADDR_HI);
  assign wr_count_lo  = io_wr && (io_addr == ddm_pkg::OFS_COUNT_LO);
  assign wr_count_hi  = io_wr && (io_addr == ddm_pkg::OFS_COUNT_HI);
  assign wr_ctrl      = io_wr && (io_addr == ddm_pkg::OFS_CTRL);
  assign wr_trigger   = io_wr && (io_addr == ddm_pkg::OFS_TRIGGER);
  assign wr_setup     = io_wr && (io_addr == ddm_pkg::OFS_SETUP);
  assign master_clear = io_wr && (io_addr == ddm_pkg::OFS_CLEAR);
  assign rd_status    = io_rd && (io_addr == ddm_pkg::OFS_CTRL);

  // ----------------------------------------------------------------
  // Setup fields
  // ----------------------------------------------------------------
  assign operating_mode_select =
    ddm_pkg::ddm_mode_e'(setup[ddm_pkg::SETUP_MODE_LO +: 2]);
  assign address_direction  = setup[ddm_pkg::SETUP_ADDR_DIR];
  assign auto_reload_enable = setup[ddm_pkg::SETUP_AUTO];
  assign transfer_direction_type =
    setup[ddm_pkg::SETUP_XDIR_LO +: 2];

  // Raw synchronised line, mask deliberately not applied
  assign card_request_status = {4{card_req_s}};
  assign card_ok = card_req_s && !socket_request_mask;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  assign count_step = xfer_wide ? ddm_pkg::STEP_WIDE
                                : ddm_pkg::STEP_NARROW;
  assign in_run   = (state == ddm_pkg::ST_RUN);
  // End of transfer when this step brings the count to zero or past it
  assign tc_event = xfer_done && in_run && (cur_count <= count_step);

  // The count always runs down; only the address obeys the setup bit
  ddm_step_counter #(.W(16)) u_count (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clr      (master_clear),
    .load_lo  (wr_count_lo),
    .load_hi  (wr_count_hi),
    .wdata    (io_wdata),
    .step_en  (xfer_done && in_run),
    .step_amt (count_step),
    .down     (1'b1),
    .reload   (tc_event && auto_reload_enable),
    .base     (base_count),
    .cur      (cur_count)
  );

  ddm_step_counter #(.W(16)) u_address (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clr      (master_clear),
    .load_lo  (wr_addr_lo),
    .load_hi  (wr_addr_hi),
    .wdata    (io_wdata),
    .step_en  (xfer_done && in_run),
    .step_amt (ddm_pkg::STEP_ADDR),
    .down     (address_direction),
    .reload   (tc_event && auto_reload_enable),
    .base     (base_address),
    .cur      (cur_address)
  );

  // ----------------------------------------------------------------
  // Register group
  // ----------------------------------------------------------------
  logic       next_disable;
  logic [7:0] next_setup;
  logic [3:0] next_tc_flags;
  logic       next_sw_pend;
  logic [7:0] next_rdata;

  always_comb begin
    next_disable  = channel_disable_bit;
    next_setup    = setup;
    next_tc_flags = terminal_count_flags;
    next_sw_pend  = sw_pend;
    next_rdata    = io_rdata;
    if (master_clear) begin
      next_disable  = 1'b0;
      next_setup    = ddm_pkg::SETUP_RESET;
      next_tc_flags = ddm_pkg::TC_NONE;
      next_sw_pend  = 1'b0;
    end else begin
      if (wr_ctrl) begin
        next_disable = io_wdata[ddm_pkg::CTRL_DISABLE_BIT];
      end
      if (wr_setup) begin
        next_setup = io_wdata & ddm_pkg::SETUP_WMASK;
      end
      // A read clears, but an arriving end of transfer wins
      if (rd_status) begin
        next_tc_flags = ddm_pkg::TC_NONE;
      end
      if (tc_event) begin
        next_tc_flags = ddm_pkg::TC_ALL;
      end
      if (tc_event) begin
        next_sw_pend = 1'b0;
      end
      if (wr_trigger) begin
        next_sw_pend = 1'b1;
      end
    end
    // Read data is registered so the bus sees a steady byte for the
    // whole cycle after the strobe
    if (io_rd) begin
      case (io_addr)
        ddm_pkg::OFS_ADDR_LO:  next_rdata = cur_address[7:0];
        ddm_pkg::OFS_ADDR_HI:  next_rdata = cur_address[15:8];
        ddm_pkg::OFS_COUNT_LO: next_rdata = cur_count[7:0];
        ddm_pkg::OFS_COUNT_HI: next_rdata = cur_count[15:8];
        ddm_pkg::OFS_CTRL:
          next_rdata = {card_request_status,
                        terminal_count_flags};
        ddm_pkg::OFS_SETUP:    next_rdata = setup;
        default:               next_rdata = ddm_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_disable_bit  <= 1'b0;
      setup                <= ddm_pkg::SETUP_RESET;
      terminal_count_flags <= ddm_pkg::TC_NONE;
      sw_pend              <= 1'b0;
      io_rdata             <= ddm_pkg::READ_ZERO;
    end else begin
      channel_disable_bit  <= next_disable;
      setup                <= next_setup;
      terminal_count_flags <= next_tc_flags;
      sw_pend              <= next_sw_pend;
      io_rdata             <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Request sequencing
  // ----------------------------------------------------------------
  // Without auto reload the channel parks in HALT after the end of a
  // transfer until software writes a new count, sets the disable bit or
  // writes the clear location, so a stale count cannot start a runaway transfer while the channel stays enabled.
  always_comb begin
    next_state = state;
    case (state)
      ddm_pkg::ST_IDLE: begin
        if (!channel_disable_bit && (transfer_direction_type !=
            ddm_pkg::XDIR_NONE) && (card_ok || sw_pend)) begin
          next_state = ddm_pkg::ST_RUN;
        end
      end
      ddm_pkg::ST_RUN: begin
        if (tc_event) begin
          next_state = auto_reload_enable ? ddm_pkg::ST_IDLE
                                          : ddm_pkg::ST_HALT;
        end else if (xfer_done &&
                     operating_mode_select == ddm_pkg::MODE_SINGLE) begin
          next_state = ddm_pkg::ST_WAIT;
        end else if (operating_mode_select != ddm_pkg::MODE_BLOCK &&
                     !card_ok && !sw_pend) begin
          next_state = ddm_pkg::ST_IDLE;
        end
      end
      // Single mode rearms only once the card lets go, so one held
      // request cannot be served twice
      ddm_pkg::ST_WAIT: begin
        if (!card_req_s || socket_request_mask) begin
          next_state = ddm_pkg::ST_IDLE;
        end
      end
      ddm_pkg::ST_HALT: begin
        if (wr_count_lo || wr_count_hi) begin
          next_state = ddm_pkg::ST_IDLE;
        end
      end
      default: next_state = ddm_pkg::ST_IDLE;
    endcase
    if (channel_disable_bit) begin
      next_state = ddm_pkg::ST_IDLE;
    end
    if (master_clear) begin
      next_state = ddm_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ddm_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign dma_req = in_run;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Plain steps leave out loads, clears and the end-of-transfer edge
  logic plain_step;
  assign plain_step = xfer_done && in_run && !tc_event &&
                      !master_clear && !wr_count_lo && !wr_count_hi;

  a_count_narrow: assert property (
    plain_step && !xfer_wide |=> cur_count == $past(cur_count) - 16'h0001)
    else $error("count did not drop by one");
  a_count_wide: assert property (
    plain_step && xfer_wide |=> cur_count == $past(cur_count) - 16'h0002)
    else $error("count did not drop by two");
  a_disable_no_req: assert property (
    channel_disable_bit && !wr_ctrl |=> !dma_req [*2])
    else $error("request while channel disabled");
  a_status_read: assert property (
    rd_status |=> io_rdata[7:4] == {4{$past(card_req_s)}} &&
                  io_rdata[3:0] == $past(terminal_count_flags))
    else $error("status read returned wrong value");
  a_tc_set_all: assert property (
    tc_event && !master_clear |=> terminal_count_flags == 4'hF)
    else $error("end of transfer did not set all flags");
  a_tc_read_clear: assert property (
    rd_status && !tc_event |=> terminal_count_flags == 4'h0)
    else $error("status read did not clear flags");
  a_trigger_pend: assert property (
    wr_trigger && !master_clear |=> sw_pend)
    else $error("trigger write lost");
  a_setup_low_zero: assert property (
    io_rd && io_addr == ddm_pkg::OFS_SETUP |=> io_rdata[1:0] == 2'b00)
    else $error("setup low bits not zero");
  a_mask_ignores: assert property (
    state == ddm_pkg::ST_IDLE && socket_request_mask && !sw_pend &&
    !wr_trigger |=> !dma_req)
    else $error("masked card request started a transfer");
  a_master_clear: assert property (
    master_clear |=> cur_count == 16'h0000 && setup == 8'h00 &&
                     terminal_count_flags == 4'h0 && !dma_req)
    else $error("clear location did not reset channel");
  a_reserved_zero: assert property (
    io_rd && io_addr == 4'h2 |=> io_rdata == 8'h00)
    else $error("reserved location read non-zero");
  a_auto_reload: assert property (
    tc_event && auto_reload_enable && !master_clear
    |=> cur_count == $past(base_count) && cur_address == $past(base_address))
    else $error("auto reload did not restore base values");

  c_tc_reached:  cover property (tc_event);
  c_tc_read:     cover property (rd_status && terminal_count_flags != 4'h0);
  c_single_wait: cover property (state == ddm_pkg::ST_WAIT);
  c_auto_reload: cover property (tc_event && auto_reload_enable);
  c_sw_block:    cover property (
    sw_pend && in_run && operating_mode_select == ddm_pkg::MODE_BLOCK);

endmodule : ddm_slave_channel
`default_nettype wire

// ==== rtl/ddm_pkg.sv ====
// Purpose: Shared constants for the distributed DMA slave channel.
// Assumes: Byte-wide I/O window of sixteen locations.
// Notes:   Offsets are byte offsets inside the window.
package ddm_pkg;

  // ----------------------------------------------------------------
  // Window offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_ADDR_LO  = 4'h0;
  localparam logic [3:0] OFS_ADDR_HI  = 4'h1;
  localparam logic [3:0] OFS_COUNT_LO = 4'h4;
  localparam logic [3:0] OFS_COUNT_HI = 4'h5;
  localparam logic [3:0] OFS_CTRL     = 4'h8;
  localparam logic [3:0] OFS_TRIGGER  = 4'h9;
  localparam logic [3:0] OFS_SETUP    = 4'hB;
  localparam logic [3:0] OFS_CLEAR    = 4'hD;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_DISABLE_BIT = 2;
  localparam int          SETUP_MODE_LO    = 6;
  localparam int          SETUP_ADDR_DIR   = 5;
  localparam int          SETUP_AUTO       = 4;
  localparam int          SETUP_XDIR_LO    = 2;
  localparam logic [7:0]  SETUP_WMASK      = 8'hFC;
  localparam logic [7:0]  SETUP_RESET      = 8'h00;
  localparam logic [3:0]  TC_ALL           = 4'hF;
  localparam logic [3:0]  TC_NONE          = 4'h0;
  localparam logic [7:0]  READ_ZERO        = 8'h00;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // Step sizes per completed transfer
  // ----------------------------------------------------------------
  localparam logic [15:0] STEP_NARROW = 16'h0001;
  localparam logic [15:0] STEP_WIDE   = 16'h0002;
  localparam logic [15:0] STEP_ADDR   = 16'h0001;

  typedef enum logic [1:0] {
    MODE_DEMAND = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_BLOCK  = 2'b10,
    MODE_RSVD   = 2'b11
  } ddm_mode_e;

  typedef enum logic [1:0] {
    XDIR_NONE  = 2'b00,
    XDIR_WRITE = 2'b01,
    XDIR_READ  = 2'b10,
    XDIR_RSVD  = 2'b11
  } ddm_xdir_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10,
    ST_HALT = 2'b11
  } ddm_state_e;

endpackage : ddm_pkg

// ==== rtl/ddm_sync.sv ====
// Purpose: Two-stage synchroniser for a level arriving from a pin.
// Assumes: Input is asynchronous to ref_clk.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/100ps
`default_nettype none
module ddm_sync (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : ddm_sync
`default_nettype wire

// ==== rtl/ddm_step_counter.sv ====
// Purpose: Base/current pair loaded bytewise, stepped up or down.
// Assumes: Priority clr, byte load, reload, step.
// Notes:   A byte load writes base and current together.
`timescale 1ns/100ps
`default_nettype none
module ddm_step_counter #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         clr,
  input  wire logic         load_lo,
  input  wire logic         load_hi,
  input  wire logic [7:0]   wdata,
  input  wire logic         step_en,
  input  wire logic [W-1:0] step_amt,
  input  wire logic         down,
  input  wire logic         reload,
  output logic      [W-1:0] base,
  output logic      [W-1:0] cur
);
  logic [W-1:0] next_base;
  logic [W-1:0] next_cur;

  if (W < 9 || W > 16) begin : g_bad_width
    $error("ddm_step_counter: W must be 9 to 16");
  end

  always_comb begin
    next_base = base;
    next_cur  = cur;
    if (clr) begin
      next_base = '0;
      next_cur  = '0;
    end else if (load_lo) begin
      next_base = {base[W-1:8], wdata};
      next_cur  = next_base;
    end else if (load_hi) begin
      next_base = {wdata[W-9:0], base[7:0]};
      next_cur  = next_base;
    end else if (reload) begin
      next_cur = base;
    end else if (step_en) begin
      next_cur = down ? cur - step_amt : cur + step_amt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      base <= '0;
      cur  <= '0;
    end else begin
      base <= next_base;
      cur  <= next_cur;
    end
  end
endmodule : ddm_step_counter
`default_nettype wire

// ==== verif/ddm_far_model.sv ====
// Purpose: Far side of the channel: card request pin and transfer engine.
// Assumes: Drives just after the rising edge, as a same-clock engine would.
// Notes:   Completes transfers only up to the budget the bench hands it.
`timescale 1ns/100ps
`default_nettype none
module ddm_far_model (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic dma_req,
  input  wire logic req_on,
  input  wire logic wide,
  input  wire logic slow,
  input  var  int   budget,
  output logic      card_request_line,
  output logic      xfer_done,
  output logic      xfer_wide,
  output var  int   ndone
);
  logic ph;

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // A gap after each completion keeps us from answering a request
  // that the channel drops at that very edge (terminal count, single)
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph                <= 1'h0;
      xfer_done         <= 1'h0;
      xfer_wide         <= 1'h0;
      ndone             <= 0;
      card_request_line <= 1'h0;
    end else begin
      ph                <= ~ph;
      card_request_line <= req_on;
      xfer_wide         <= wide;
      if (dma_req && !xfer_done && ndone < budget && (!slow || ph)) begin
        xfer_done <= 1'h1;
        ndone     <= ndone + 1;
      end else begin
        xfer_done <= 1'h0;
      end
    end
  end
endmodule : ddm_far_model
`default_nettype wire

// ==== verif/test_ddm_slave_channel.sv ====
// Purpose: Self-checking bench for the DMA slave channel registers.
// Assumes: Byte window strobes driven on the falling edge.
// Notes:   Expected values are worked out here, never read back.
`timescale 1ns/100ps
`default_nettype none
module test_ddm_slave_channel;
  localparam int LIMIT = 20000;

  logic        ref_clk;
  logic        rst_b;
  logic [3:0]  io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        card_request_line;
  logic        socket_request_mask;
  logic        xfer_done;
  logic        xfer_wide;
  logic        dma_req;
  logic [15:0] cur_address;
  logic [15:0] cur_count;
  logic        address_direction;
  logic [1:0]  transfer_direction_type;
  logic        req_on;
  logic        wide;
  logic        slow;
  int          budget;
  int          ndone;
  int          mismatches;
  int          cmp_count;
  int          tcyc;
  logic [7:0]  rdv;
  logic [7:0]  v;
  logic [3:0]  rsv [8] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hC, 4'hE, 4'hF};

  ddm_slave_channel i_dut (
    .ref_clk                 (ref_clk),
    .rst_b                   (rst_b),
    .io_addr                 (io_addr),
    .io_wr                   (io_wr),
    .io_rd                   (io_rd),
    .io_wdata                (io_wdata),
    .io_rdata                (io_rdata),
    .card_request_line       (card_request_line),
    .socket_request_mask     (socket_request_mask),
    .xfer_done               (xfer_done),
    .xfer_wide               (xfer_wide),
    .dma_req                 (dma_req),
    .cur_address             (cur_address),
    .cur_count               (cur_count),
    .address_direction       (address_direction),
    .transfer_direction_type (transfer_direction_type)
  );

  ddm_far_model i_far (
    .ref_clk           (ref_clk),
    .rst_b             (rst_b),
    .dma_req           (dma_req),
    .req_on            (req_on),
    .wide              (wide),
    .slow              (slow),
    .budget            (budget),
    .card_request_line (card_request_line),
    .xfer_done         (xfer_done),
    .xfer_wide         (xfer_wide),
    .ndone             (ndone)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    tcyc <= tcyc + 1;
    if (tcyc == LIMIT) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'h1;
    @(negedge ref_clk);
    io_wr = 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(negedge ref_clk);
    io_addr = a;
    io_rd   = 1'h1;
    @(negedge ref_clk);
    io_rd = 1'h0;
    rdv   = io_rdata;
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(rdv, e);
  endtask : rchk

  // Low byte first, then high byte of a two-byte register
  task automatic cnt_chk(input logic [3:0] a, input logic [15:0] e);
    logic [7:0] lo;
    rd(a);
    lo = rdv;
    rd(4'(a + 4'h1));
    chk({rdv, lo}, e);
  endtask : cnt_chk

  task automatic xfers(input int n);
    budget = budget + n;
    for (int k = 0; k < 300 && ndone != budget; k++) begin
      @(negedge ref_clk);
    end
    chk(16'(ndone), 16'(budget));
    cyc(3);
  endtask : xfers

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    io_addr = 4'h0;
    io_wr = 1'h0;
    io_rd = 1'h0;
    io_wdata = 8'h00;
    socket_request_mask = 1'h0;
    req_on = 1'h0;
    wide = 1'h0;
    slow = 1'h0;
    budget = 0;
    mismatches = 0;
    cmp_count = 0;
    cyc(4);
    rst_b = 1'h1;
    cnt_chk(4'h4, 16'h0000);
    rchk(4'h8, 8'h00);
    rchk(4'hB, 8'h00);
    for (int i = 0; i < 16; i++) begin
      v = 8'(i);
      wr(4'hB, {v[3:0], v[1:0], 2'h3});
      rchk(4'hB, {v[3:0], v[1:0], 2'h0});
      chk(address_direction, v[1]);
      chk(transfer_direction_type, v[1:0]);
    end
    wr(4'h8, 8'hFF);
    rchk(4'h8, 8'h00);
    req_on = 1'h1;
    wr(4'hB, 8'h04);
    cyc(4);
    rchk(4'h8, 8'hF0);
    chk(dma_req, 1'h0);
    socket_request_mask = 1'h1;
    wr(4'h8, 8'h00);
    cyc(4);
    chk(dma_req, 1'h0);
    rchk(4'h8, 8'hF0);
    socket_request_mask = 1'h0;
    cyc(4);
    chk(dma_req, 1'h1);
    wr(4'h0, 8'h34);
    wr(4'h1, 8'h12);
    wr(4'h4, 8'h10);
    wr(4'h5, 8'h00);
    xfers(3);
    cnt_chk(4'h4, 16'h000D);
    chk(cur_address, 16'h1237);
    wide = 1'h1;
    xfers(2);
    cnt_chk(4'h4, 16'h0009);
    wr(4'hB, 8'h24);
    xfers(1);
    chk(cur_address, 16'h1238);
    chk(cur_count, 16'h0007);
    // Count of four in wide steps ends on the second completion
    wr(4'h4, 8'h04);
    wr(4'h5, 8'h00);
    xfers(2);
    rchk(4'h8, 8'hFF);
    rchk(4'h8, 8'hF0);
    wr(4'hB, 8'h14);
    wide = 1'h0;
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h20);
    wr(4'h4, 8'h03);
    wr(4'h5, 8'h00);
    xfers(3);
    chk(cur_count, 16'h0003);
    chk(cur_address, 16'h2000);
    rchk(4'h8, 8'hFF);
    req_on = 1'h0;
    // Let demand mode drop the request before block mode holds it
    cyc(4);
    wr(4'hB, 8'h84);
    wr(4'h4, 8'h05);
    wr(4'h5, 8'h00);
    cyc(4);
    chk(dma_req, 1'h0);
    // Software request issued with the channel in block mode
    wr(4'h9, 8'h5A);
    cyc(3);
    chk(dma_req, 1'h1);
    rchk(4'h9, 8'h00);
    slow = 1'h1;
    xfers(2);
    chk(cur_count, 16'h0003);
    wr(4'hD, 8'h00);
    rchk(4'hB, 8'h00);
    cnt_chk(4'h4, 16'h0000);
    chk(cur_address, 16'h0000);
    chk(dma_req, 1'h0);
    rchk(4'h8, 8'h00);
    // Single mode: one transfer per request, rearms after release
    wr(4'hB, 8'h44);
    wr(4'h4, 8'h08);
    req_on = 1'h1;
    cyc(5);
    chk(dma_req, 1'h1);
    xfers(1);
    chk(dma_req, 1'h0);
    chk(cur_count, 16'h0007);
    req_on = 1'h0;
    cyc(5);
    req_on = 1'h1;
    cyc(5);
    chk(dma_req, 1'h1);
    req_on = 1'h0;
    cyc(5);
    chk(dma_req, 1'h0);
    wr(4'hB, 8'h88);
    for (int i = 0; i < 8; i++) begin
      wr(rsv[i], 8'hFF);
    end
    for (int i = 0; i < 8; i++) begin
      rchk(rsv[i], 8'h00);
    end
    rchk(4'hB, 8'h88);
    final_report();
  end
endmodule : test_ddm_slave_channel
`default_nettype wire
